//--- common/ovf_timer_regs.vh
/*
 * register map, field positions, reset values and timing constants of the
 * sixteen bit overflow timer.
 * assumes byte wide register port and one 10 MHz system clock.
 */
`ifndef OVF_TIMER_REGS_VH
`define OVF_TIMER_REGS_VH

// register addresses
`define ADDR_COUNT_LO      3'h0
`define ADDR_COUNT_HI      3'h1
`define ADDR_TIMER_CTL     3'h2
`define ADDR_IRQ_STATUS    3'h3
`define ADDR_IRQ_CLEAR     3'h4
`define ADDR_IRQ_ENABLE    3'h5

// timer_ctl fields
`define CTL_WIDE_ACCESS    7
`define CTL_SYSCLK_XTAL    6
`define CTL_PRESCALE_HI    5
`define CTL_PRESCALE_LO    4
`define CTL_XTAL_ENABLE    3
`define CTL_SYNC_DISABLE   2
`define CTL_CLK_SOURCE     1
`define CTL_COUNTER_ON     0
`define CTL_WRITE_MASK     8'hbf

// status, clear and enable share one layout
`define IRQ_OVERFLOW_BIT   0

// reset values
`define CTL_RESET          8'h00
`define COUNT_RESET        16'h0000
`define IRQ_RESET          1'b0

// counter limits
`define COUNT_MAX          16'hffff
`define COUNT_ONE          16'h0001

// compare mode that issues the special event trigger
`define SPECIAL_EVENT_MODE 4'hb

// instruction cycle is four system clocks
`define INSTR_DIV_LAST     2'h3
`define INSTR_DIV_STEP     2'h1

// prescaler select codes
`define PRESCALE_1         2'h0
`define PRESCALE_2         2'h1
`define PRESCALE_4         2'h2
`define PRESCALE_8         2'h3

`endif

//--- design/pin_sync.v
/*
 * two flip-flop synchroniser for an external clock pin, with edge detect
 * taken after the second stage.
 * assumes the pin is asynchronous to i_clk and slower than half its rate.
 */
`timescale 1ns/1ps
module pin_sync (
   input  wire i_clk,
   input  wire i_reset,
   input  wire i_pin,
   output wire o_level,
   output wire o_rise,
   output wire o_fall
);
   reg meta_q;
   reg sync_q;
   reg prev_q;

   // first stage feeds only the second stage
   always @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign o_level = sync_q;
   assign o_rise  = sync_q & ~prev_q;
   assign o_fall  = ~sync_q & prev_q;
endmodule

//--- design/count_prescaler.v
/*
 * input prescaler: passes one tick in 1, 2, 4 or 8.
 * assumes i_tick is a one-cycle pulse on i_clk.
 */
`timescale 1ns/1ps
`include "ovf_timer_regs.vh"
module count_prescaler (
   input  wire       i_clk,
   input  wire       i_reset,
   input  wire       i_clear,
   input  wire       i_tick,
   input  wire [1:0] i_sel,
   output wire       o_tick
);
   reg  [2:0] cnt_q;
   reg  [2:0] mask;

   always @* begin
      case (i_sel)
         `PRESCALE_1: mask = 3'h0;
         `PRESCALE_2: mask = 3'h1;
         `PRESCALE_4: mask = 3'h3;
         default:     mask = 3'h7;
      endcase
   end

   assign o_tick = i_tick & ((cnt_q & mask) == mask);

   always @(posedge i_clk) begin
      if (i_reset | i_clear) begin
         cnt_q <= 3'h0;
      end else if (i_tick) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
endmodule

//--- design/ovf_timer.v
/*
 * sixteen bit overflow timer/counter with byte wide registers, overflow
 * interrupt and compare-unit special event reset.
 * assumes one system clock, a pin level for the external count clock,
 * and compare units that present mode, selection and event pulse.
 */
// Strobed register access and the address map are this design's own decisions.
// Function
// - counter pair counts up from 0000h to ffffh, then wraps to zero
// - wrap sets sticky overflow flag bit 0; irq only when enable bit 0
// - compare unit on this timer with mode 1011 clears counter on event
// - unit two event also starts a conversion when converter enabled
// - trigger reset holds only in timer or synchronous counter mode
// - compare pair then acts as period; count restarts from zero
// - software counter write in same cycle as trigger wins
// - trigger clear never sets the overflow flag
// - async mode after a write needs a falling edge before next count
// - counter and control registers mapped only while map select is 0
// - source select 0 counts instruction cycles, 1 external rising edges
// - prescale 00,01,10,11 divide by 1,2,4,8 before counting
// - sync disable bit chooses synchronised or free external counting
// - wide mode: low read latches high; low write loads high, clears
`timescale 1ns/1ps
`include "ovf_timer_regs.vh"
module ovf_timer (
   input  wire       i_clk,
   input  wire       i_reset,
   input  wire [2:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output wire [7:0] o_rdata,
   input  wire       i_alt_map_sel,
   input  wire       i_ext_clk,
   input  wire       i_sysclk_from_crystal,
   input  wire [3:0] i_unit_one_mode,
   input  wire       i_unit_one_uses_timer,
   input  wire       i_unit_one_event,
   input  wire [3:0] i_unit_two_mode,
   input  wire       i_unit_two_uses_timer,
   input  wire       i_unit_two_event,
   input  wire       i_adc_enable,
   output wire       o_adc_start,
   output wire       o_crystal_osc_enable,
   output wire [15:0] o_count,
   output wire       o_irq
);

   // control register fields
   reg  [7:0]  timer_ctl_q;
   wire        wide_access_mode;
   wire [1:0]  prescale_sel;
   wire        crystal_osc_enable;
   wire        ext_sync_disable;
   wire        clock_source_sel;
   wire        counter_on;
   wire        async_mode;

   // counter state
   reg  [15:0] count_q;
   reg  [15:0] count_d;
   reg  [7:0]  hi_buffer_q;
   reg  [1:0]  instr_div_q;
   reg         arm_q;

   // interrupt state
   reg         overflow_flag_q;
   reg         overflow_irq_enable_q;
   reg         irq_q;

   // bus and side outputs
   reg  [7:0]  rdata_q;
   reg  [7:0]  rdata_d;
   reg         adc_start_q;
   reg         xtal_en_q;

   wire        ext_level;
   wire        ext_rise;
   wire        ext_fall;
   wire        instr_tick;
   wire        src_tick;
   wire        count_tick;
   wire        map_ok;
   wire        wr_lo;
   wire        wr_hi;
   wire        rd_lo;
   wire        counter_write;
   wire        prescale_clear;
   wire        unit_one_trig;
   wire        unit_two_trig;
   wire        trig_reset;
   wire        wrap;
   wire        overflow_set;
   wire        overflow_clr;
   wire        overflow_flag_d;

   function is_special_event;
      input [3:0] mode;
      input       uses_timer;
      input       event_pulse;
      begin
         is_special_event = event_pulse & uses_timer &
                            (mode == `SPECIAL_EVENT_MODE);
      end
   endfunction

   function reg_hit;
      input       strobe;
      input [2:0] addr;
      input [2:0] target;
      begin
         reg_hit = strobe & (addr == target);
      end
   endfunction

   assign wide_access_mode   = timer_ctl_q[`CTL_WIDE_ACCESS];
   assign prescale_sel       = timer_ctl_q[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
   assign crystal_osc_enable = timer_ctl_q[`CTL_XTAL_ENABLE];
   assign ext_sync_disable   = timer_ctl_q[`CTL_SYNC_DISABLE];
   assign clock_source_sel   = timer_ctl_q[`CTL_CLK_SOURCE];
   assign counter_on         = timer_ctl_q[`CTL_COUNTER_ON];
   // sync disable only matters with the external source
   assign async_mode         = clock_source_sel & ext_sync_disable;

   // the shared addresses belong to another register set when selected
   assign map_ok = ~i_alt_map_sel;

   assign wr_lo = map_ok & reg_hit(i_wr, i_addr, `ADDR_COUNT_LO);
   assign wr_hi = map_ok & reg_hit(i_wr, i_addr, `ADDR_COUNT_HI);
   assign rd_lo = map_ok & reg_hit(i_rd, i_addr, `ADDR_COUNT_LO);

   // in wide mode a high write only fills the buffer
   assign counter_write  = wr_lo | (wr_hi & ~wide_access_mode);
   // wide mode clears the prescaler on low writes only
   assign prescale_clear = wide_access_mode ? wr_lo : counter_write;

   // even "unsynchronised" counting goes through the synchroniser: the
   // design has one clock, so count and flag never leave its domain
   pin_sync u_ext_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_pin   (i_ext_clk),
      .o_level (ext_level),
      .o_rise  (ext_rise),
      .o_fall  (ext_fall)
   );

   // instruction cycle tick, one in four system clocks
   always @(posedge i_clk) begin
      if (i_reset) begin
         instr_div_q <= 2'h0;
      end else begin
         instr_div_q <= instr_div_q + `INSTR_DIV_STEP;
      end
   end
   assign instr_tick = (instr_div_q == `INSTR_DIV_LAST);

   // after a write in async mode a falling edge must re-arm counting, so
   // a write that lands while the input is already low loses one edge
   always @(posedge i_clk) begin
      if (i_reset) begin
         arm_q <= 1'b1;
      end else if (counter_write & async_mode) begin
         arm_q <= 1'b0;
      end else if (ext_fall) begin
         arm_q <= 1'b1;
      end
   end

   assign src_tick = clock_source_sel ?
                     (ext_rise & (arm_q | ~async_mode)) :
                     instr_tick;

   count_prescaler u_prescale (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_clear (prescale_clear),
      .i_tick  (src_tick & counter_on),
      .i_sel   (prescale_sel),
      .o_tick  (count_tick)
   );

   assign unit_one_trig = is_special_event(i_unit_one_mode,
                                           i_unit_one_uses_timer,
                                           i_unit_one_event);
   assign unit_two_trig = is_special_event(i_unit_two_mode,
                                           i_unit_two_uses_timer,
                                           i_unit_two_event);
   // async counting does not honour the trigger reset
   assign trig_reset = (unit_one_trig | unit_two_trig) & ~async_mode;

   assign wrap = count_tick & (count_q == `COUNT_MAX);

   // counter next value: write, then trigger, then increment
   always @* begin
      count_d = count_q;
      if (counter_write) begin
         if (wr_lo & wide_access_mode) begin
            count_d = {hi_buffer_q, i_wdata};
         end else if (wr_lo) begin
            count_d = {count_q[15:8], i_wdata};
         end else begin
            count_d = {i_wdata, count_q[7:0]};
         end
      end else if (trig_reset) begin
         count_d = `COUNT_RESET;
      end else if (count_tick) begin
         count_d = count_q + `COUNT_ONE;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         count_q <= `COUNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // high byte buffer: filled by wide-mode low reads and by wide-mode high writes
   always @(posedge i_clk) begin
      if (i_reset) begin
         hi_buffer_q <= 8'h00;
      end else if (wr_hi & wide_access_mode) begin
         hi_buffer_q <= i_wdata;
      end else if (rd_lo & wide_access_mode) begin
         hi_buffer_q <= count_q[15:8];
      end
   end

   // control register; bit 6 mirrors the clock status input
   always @(posedge i_clk) begin
      if (i_reset) begin
         timer_ctl_q <= `CTL_RESET;
      end else if (map_ok & reg_hit(i_wr, i_addr, `ADDR_TIMER_CTL)) begin
         timer_ctl_q <= i_wdata & `CTL_WRITE_MASK;
      end
   end

   // only a genuine wrap sets the flag, and a write or trigger in the
   // same cycle pre-empts the wrap
   assign overflow_set = wrap & ~counter_write & ~trig_reset;
   assign overflow_clr = reg_hit(i_wr, i_addr, `ADDR_IRQ_CLEAR) &
                         i_wdata[`IRQ_OVERFLOW_BIT];
   // set beats clear so a wrap during the clear is kept
   assign overflow_flag_d = overflow_set |
                            (overflow_flag_q & ~overflow_clr);

   always @(posedge i_clk) begin
      if (i_reset) begin
         overflow_flag_q       <= `IRQ_RESET;
         overflow_irq_enable_q <= `IRQ_RESET;
         irq_q                 <= 1'b0;
      end else begin
         overflow_flag_q <= overflow_flag_d;
         if (reg_hit(i_wr, i_addr, `ADDR_IRQ_ENABLE)) begin
            overflow_irq_enable_q <= i_wdata[`IRQ_OVERFLOW_BIT];
         end
         irq_q <= overflow_flag_q & overflow_irq_enable_q;
      end
   end

   // conversion start follows unit two's event in any counting mode
   always @(posedge i_clk) begin
      if (i_reset) begin
         adc_start_q <= 1'b0;
         xtal_en_q   <= 1'b0;
      end else begin
         adc_start_q <= unit_two_trig & i_adc_enable;
         xtal_en_q   <= crystal_osc_enable;
      end
   end

   // read mux; unmapped or hidden addresses read zero
   always @* begin
      rdata_d = 8'h00;
      case (i_addr)
         `ADDR_COUNT_LO: begin
            if (map_ok) begin
               rdata_d = count_q[7:0];
            end
         end
         `ADDR_COUNT_HI: begin
            if (map_ok) begin
               rdata_d = wide_access_mode ? hi_buffer_q : count_q[15:8];
            end
         end
         `ADDR_TIMER_CTL: begin
            if (map_ok) begin
               rdata_d = timer_ctl_q;
               rdata_d[`CTL_SYSCLK_XTAL] = i_sysclk_from_crystal;
            end
         end
         `ADDR_IRQ_STATUS: begin
            rdata_d[`IRQ_OVERFLOW_BIT] = overflow_flag_q;
         end
         `ADDR_IRQ_ENABLE: begin
            rdata_d[`IRQ_OVERFLOW_BIT] = overflow_irq_enable_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // read data stands for exactly the cycle after the strobe
   always @(posedge i_clk) begin
      if (i_reset) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata              = rdata_q;
   assign o_adc_start          = adc_start_q;
   assign o_crystal_osc_enable = xtal_en_q;
   assign o_count              = count_q;
   assign o_irq                = irq_q;

endmodule

//--- tb/ovf_timer_assertions.sv
/* port checks for the overflow timer, bound to ovf_timer.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "ovf_timer_regs.vh"
module ovf_timer_assertions (
   input wire        i_clk,
   input wire        i_reset,
   input wire [2:0]  i_addr,
   input wire [7:0]  i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [7:0]  o_rdata,
   input wire        i_alt_map_sel,
   input wire [3:0]  i_unit_one_mode,
   input wire        i_unit_one_uses_timer,
   input wire        i_unit_one_event,
   input wire [3:0]  i_unit_two_mode,
   input wire        i_unit_two_uses_timer,
   input wire        i_unit_two_event,
   input wire        i_adc_enable,
   input wire        o_adc_start,
   input wire [15:0] o_count,
   input wire        o_irq
);
   reg  [7:0] ctl_q;
   reg        en_q;
   wire       trig_one;
   wire       trig_two;
   wire       trig;
   wire       sync_mode;
   assign trig_one = i_unit_one_event & i_unit_one_uses_timer
                     & (i_unit_one_mode == `SPECIAL_EVENT_MODE);
   assign trig_two = i_unit_two_event & i_unit_two_uses_timer
                     & (i_unit_two_mode == `SPECIAL_EVENT_MODE);
   assign trig = trig_one | trig_two;
   // async counting may miss the trigger, so only sync modes are held to it
   assign sync_mode = ~(ctl_q[`CTL_CLK_SOURCE] & ctl_q[`CTL_SYNC_DISABLE]);
   always @(posedge i_clk) begin
      if (i_reset) begin
         ctl_q <= `CTL_RESET;
         en_q <= `IRQ_RESET;
      end else if (i_wr) begin
         if (i_addr == `ADDR_TIMER_CTL && !i_alt_map_sel)
            ctl_q <= i_wdata & `CTL_WRITE_MASK;
         if (i_addr == `ADDR_IRQ_ENABLE)
            en_q <= i_wdata[`IRQ_OVERFLOW_BIT];
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   sequence wrap_s;
      o_count == `COUNT_MAX && !i_wr && !trig ##1 o_count == 16'h0000;
   endsequence
   AST_WRAP_IRQ: assert property (wrap_s ##0 en_q |-> ##[0:1] o_irq)
      else $error("wrap without interrupt");
   AST_MASKED: assert property (!en_q ##1 !en_q |-> !o_irq)
      else $error("interrupt while disabled");
   AST_COUNT_STEP: assert property (!$past(i_wr) && !$past(i_reset) |->
      o_count == $past(o_count) + 16'h0001 || o_count == $past(o_count)
      || o_count == 16'h0000) else $error("counter jumped");
   AST_TRIG_CLEAR: assert property (trig && !i_wr && sync_mode |->
      ##1 o_count == 16'h0000) else $error("trigger did not clear");
   AST_NO_FLAG: assert property (trig && en_q && !o_irq
      && o_count > 16'h0004 && o_count < 16'hfff0 |=> !o_irq [*3])
      else $error("trigger raised the interrupt");
   AST_WRITE_WINS: assert property (trig && i_wr && !i_alt_map_sel
      && i_addr == `ADDR_COUNT_LO && !ctl_q[`CTL_WIDE_ACCESS]
      |=> o_count[7:0] == $past(i_wdata)) else $error("trigger beat write");
   AST_ADC_START: assert property (trig_two && i_adc_enable
      |=> o_adc_start) else $error("no conversion start");
   AST_HIDDEN: assert property (i_rd && i_alt_map_sel
      && i_addr <= `ADDR_TIMER_CTL |=> o_rdata == 8'h00)
      else $error("hidden register readable");
endmodule
bind ovf_timer ovf_timer_assertions chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_alt_map_sel(i_alt_map_sel), .i_unit_one_mode(i_unit_one_mode),
   .i_unit_one_uses_timer(i_unit_one_uses_timer),
   .i_unit_one_event(i_unit_one_event), .i_unit_two_mode(i_unit_two_mode),
   .i_unit_two_uses_timer(i_unit_two_uses_timer),
   .i_unit_two_event(i_unit_two_event), .i_adc_enable(i_adc_enable),
   .o_adc_start(o_adc_start), .o_count(o_count), .o_irq(o_irq)
);

//--- tb/crystal_clock_model.sv
/* low-power crystal stand-in driving the external count pin.
   assumes the timer switches it through its oscillator enable output. */
`timescale 1ns/1ps
module crystal_clock_model #(
   parameter HALF_NS = 1000
) (
   input  wire i_enable,
   output reg  o_clk
);
   // half period shortened from the watch crystal to keep the run short
   initial o_clk = 1'b0;
   always begin
      #(HALF_NS);
      o_clk = i_enable ? ~o_clk : 1'b0;
   end
endmodule

//--- tb/ovf_timer_bench.sv
/* self-checking bench for the overflow timer.
   assumes the register header and the crystal model are compiled first. */
`timescale 1ns/1ps
`include "ovf_timer_regs.vh"
module ovf_timer_bench;
   reg         i_clk = 1'b0;
   reg         i_reset = 1'b1;
   reg  [2:0]  i_addr = 3'h0;
   reg  [7:0]  i_wdata = 8'h00;
   reg         i_wr = 1'b0;
   reg         i_rd = 1'b0;
   reg         i_alt_map_sel = 1'b0;
   reg  [3:0]  mode = 4'h0;
   reg         uses = 1'b1;
   reg         ev_one = 1'b0;
   reg         ev_two = 1'b0;
   reg         adc_en = 1'b0;
   wire [7:0]  o_rdata;
   wire [15:0] o_count;
   wire        o_irq;
   wire        o_adc_start;
   wire        xtal_en;
   wire        ext_clk;
   integer     errors;
   integer     n_tests;
   integer     s;
   integer     k;
   always #50 i_clk = ~i_clk;
   ovf_timer uut (
      .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_alt_map_sel(i_alt_map_sel), .i_ext_clk(ext_clk),
      .i_sysclk_from_crystal(1'b0), .i_unit_one_mode(mode),
      .i_unit_one_uses_timer(uses), .i_unit_one_event(ev_one),
      .i_unit_two_mode(mode), .i_unit_two_uses_timer(uses),
      .i_unit_two_event(ev_two), .i_adc_enable(adc_en),
      .o_adc_start(o_adc_start), .o_crystal_osc_enable(xtal_en),
      .o_count(o_count), .o_irq(o_irq)
   );
   crystal_clock_model xtal (.i_enable(xtal_en), .o_clk(ext_clk));
   task end_of_test;
      begin
         $display("checks %0d errors %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input string n, input [15:0] e, input [15:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task bound(input integer c);
      begin
         if (c >= 400) begin
            errors = errors + 1;
            $display("CHECK FAILED wait expected done seen timeout");
            end_of_test;
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(posedge i_clk);
         i_wr <= 1'b1;
         i_addr <= a;
         i_wdata <= d;
         @(posedge i_clk);
         i_wr <= 1'b0;
         #1;
      end
   endtask
   task rc(input string n, input [2:0] a, input [7:0] e);
      begin
         @(posedge i_clk);
         i_rd <= 1'b1;
         i_addr <= a;
         @(posedge i_clk);
         i_rd <= 1'b0;
         #1 chk(n, {8'h00, e}, {8'h00, o_rdata});
      end
   endtask
   task wait_ext(input v);
      integer c;
      begin
         for (c = 0; c < 400 && ext_clk !== v; c = c + 1)
            @(posedge i_clk);
         bound(c);
      end
   endtask
   task trig_case(input [1:0] w, input [3:0] m, input a, input u);
      reg hit;
      begin
         // only a unit that uses this timer and is in special event mode
         hit = u & (m == `SPECIAL_EVENT_MODE);
         wr(`ADDR_COUNT_HI, 8'h01);
         @(posedge i_clk);
         mode <= m;
         uses <= u;
         adc_en <= a;
         ev_one <= w[0];
         ev_two <= w[1];
         @(posedge i_clk);
         ev_one <= 1'b0;
         ev_two <= 1'b0;
         #1 chk("adc start", {15'h0, a & w[1] & hit},
                {15'h0, o_adc_start});
         chk("high byte", hit ? 16'h0000 : 16'h0001,
             {8'h00, o_count[15:8]});
      end
   endtask
   task ext_case(input [7:0] c, input ph, input [15:0] e);
      begin
         wr(`ADDR_TIMER_CTL, c);
         wr(`ADDR_COUNT_HI, 8'h00);
         chk("osc enable", {15'h0, c[3]}, {15'h0, xtal_en});
         wait_ext(~ph);
         wait_ext(ph);
         // write after the synchronised edge has landed; a write while
         // high leaves room for the fall that re-arms counting
         repeat (4) @(posedge i_clk);
         wr(`ADDR_COUNT_LO, 8'h00);
         if (ph)
            wait_ext(1'b0);
         wait_ext(1'b1);
         repeat (6) @(posedge i_clk);
         #1 chk("external count", e, o_count);
      end
   endtask
   initial begin
      errors = 0;
      n_tests = 0;
      repeat (8) @(posedge i_clk);
      i_reset <= 1'b0;
      rc("control", `ADDR_TIMER_CTL, `CTL_RESET);
      rc("status", `ADDR_IRQ_STATUS, 8'h00);
      rc("unmapped", 3'h6, 8'h00);
      wr(`ADDR_COUNT_HI, 8'h12);
      wr(`ADDR_COUNT_LO, 8'h34);
      rc("low byte", `ADDR_COUNT_LO, 8'h34);
      rc("high byte", `ADDR_COUNT_HI, 8'h12);
      wr(`ADDR_TIMER_CTL, 8'h80);
      wr(`ADDR_COUNT_HI, 8'hab);
      chk("buffered", 16'h1234, o_count);
      wr(`ADDR_COUNT_LO, 8'hcd);
      chk("wide load", 16'habcd, o_count);
      rc("wide low", `ADDR_COUNT_LO, 8'hcd);
      rc("wide high", `ADDR_COUNT_HI, 8'hab);
      i_alt_map_sel <= 1'b1;
      wr(`ADDR_COUNT_LO, 8'h00);
      rc("hidden", `ADDR_COUNT_LO, 8'h00);
      chk("unchanged", 16'habcd, o_count);
      i_alt_map_sel <= 1'b0;
      for (s = 0; s < 4; s = s + 1) begin
         wr(`ADDR_TIMER_CTL, {2'b00, s[1:0], 4'h0});
         wr(`ADDR_COUNT_HI, 8'h00);
         wr(`ADDR_COUNT_LO, 8'h00);
         wr(`ADDR_TIMER_CTL, {2'b00, s[1:0], 4'h1});
         repeat (64) @(posedge i_clk);
         wr(`ADDR_TIMER_CTL, {2'b00, s[1:0], 4'h0});
         // one tick of slack for the free-running instruction phase
         chk("prescale", 16'h0001,
             {15'h0, o_count - (16'h0010 >> s) <= 16'h0001});
      end
      wr(`ADDR_IRQ_ENABLE, 8'h01);
      wr(`ADDR_COUNT_HI, 8'hff);
      wr(`ADDR_COUNT_LO, 8'hf8);
      wr(`ADDR_TIMER_CTL, 8'h01);
      for (k = 0; k < 400 && o_irq !== 1'b1; k = k + 1)
         @(posedge i_clk);
      bound(k);
      rc("status", `ADDR_IRQ_STATUS, 8'h01);
      chk("wrapped", 16'h0000, {8'h00, o_count[15:8]});
      wr(`ADDR_COUNT_HI, 8'h80);
      chk("preload", 16'h0080, {8'h00, o_count[15:8]});
      wr(`ADDR_IRQ_CLEAR, 8'h01);
      repeat (2) @(posedge i_clk);
      #1 chk("irq cleared", 16'h0000, {15'h0, o_irq});
      wr(`ADDR_IRQ_ENABLE, 8'h00);
      wr(`ADDR_COUNT_HI, 8'hff);
      wr(`ADDR_COUNT_LO, 8'hf8);
      repeat (60) @(posedge i_clk);
      rc("masked status", `ADDR_IRQ_STATUS, 8'h01);
      chk("masked irq", 16'h0000, {15'h0, o_irq});
      wr(`ADDR_IRQ_CLEAR, 8'h01);
      wr(`ADDR_IRQ_ENABLE, 8'h01);
      trig_case(2'b01, `SPECIAL_EVENT_MODE, 1'b1, 1'b1);
      trig_case(2'b10, `SPECIAL_EVENT_MODE, 1'b1, 1'b1);
      trig_case(2'b10, `SPECIAL_EVENT_MODE, 1'b0, 1'b1);
      trig_case(2'b11, `SPECIAL_EVENT_MODE, 1'b1, 1'b0);
      trig_case(2'b11, 4'ha, 1'b1, 1'b1);
      rc("no flag", `ADDR_IRQ_STATUS, 8'h00);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= `ADDR_COUNT_LO;
      i_wdata <= 8'h55;
      mode <= `SPECIAL_EVENT_MODE;
      ev_one <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      ev_one <= 1'b0;
      #1 chk("write wins", 16'h0055, {8'h00, o_count[7:0]});
      ext_case(8'h0f, 1'b0, 16'h0000);
      ext_case(8'h0b, 1'b0, 16'h0001);
      ext_case(8'h0f, 1'b1, 16'h0001);
      end_of_test;
   end
endmodule
